// ==== rtl/acs_pkg.sv ====
// Shared constants and types for the serial command and chain control block.
// Assumes one system clock domain and one serial link clock domain.
package acs_pkg;

    // Serial byte geometry
    localparam int BYTE_W = 8;
    // Bit count (minus one) at which single-byte system opcodes are decided
    localparam logic [2:0] EARLY_BIT_IDX = 3'h6;
    // Bit count (minus one) at which a whole byte is complete
    localparam logic [2:0] FULL_BIT_IDX = 3'h7;

    // System opcodes
    localparam logic [7:0] WAKE_CMD = 8'h02;
    localparam logic [7:0] STANDBY_CMD = 8'h04;
    localparam logic [7:0] RESET_CMD = 8'h06;
    localparam logic [7:0] START_CMD = 8'h08;
    localparam logic [7:0] STOP_CMD = 8'h0A;

    // Data read opcodes
    localparam logic [7:0] CONTINUOUS_READ_CMD = 8'h10;
    localparam logic [7:0] HALT_CONTINUOUS_READ_CMD = 8'h11;
    localparam logic [7:0] SINGLE_READ_CMD = 8'h12;

    // Register access opcodes: three-bit prefix, five-bit field
    localparam logic [2:0] REGISTER_READ_CMD = 3'h1;
    localparam logic [2:0] REGISTER_WRITE_CMD = 3'h2;
    localparam int PREFIX_LSB = 5;
    localparam int FIELD_W = 5;

    // Reset values
    localparam logic CONT_READ_RST = 1'b1;
    localparam logic DONE_N_RST = 1'b1;
    localparam logic [7:0] TX_IDLE_BYTE = 8'h00;

    // Default sizes and timing
    localparam int FRAME_BYTES_DEF = 27;
    localparam int CONV_CYCLES_DEF = 1024;

    // Command sequencer states, one-hot
    typedef enum logic [3:0] {
        CMD_IDLE = 4'h1,
        CMD_COUNT = 4'h2,
        CMD_WRITE = 4'h4,
        CMD_READ = 4'h8
    } acs_cmd_t;

    // True when the seven upper bits of a byte match an opcode
    function automatic logic acs_match7(input logic [7:0] rx, input logic [7:0] op);
        return rx[7:1] == op[7:1];
    endfunction

endpackage

// ==== rtl/acs_serial_link.sv ====
// Serial-clock side of the command port: byte capture and output shifting.
// Assumes the system side holds txByte/txPass stable across a byte boundary
// and samples rxByte/rxEarly only after it sees rxToggle change.
`timescale 1ns/100ps

module acs_serial_link (
    // Link clock, frame and reset
    input wire logic sclk,
    input wire logic csN,
    input wire logic reset_n,
    // Serial pins
    input wire logic din,
    input wire logic chainIn,
    output logic dout,
    output logic doutOe,
    // Transmit word from the system side
    input wire logic [7:0] txByte,
    input wire logic txPass,
    // Receive word to the system side
    output logic [7:0] rxByte,
    output logic rxEarly,
    output logic rxToggle
);

    logic [2:0] bitCnt_q, bitCnt_d;   // Falling edges seen in this byte
    logic [6:0] rxSh_q, rxSh_d;       // Incoming bits, MSB first
    logic [7:0] rxByte_q, rxByte_d;   // Word handed to the system side
    logic rxEarly_q, rxEarly_d;       // Word is a seven-bit early decode
    logic rxTog_q, rxTog_d;           // Event toggle
    logic [7:0] txSh_q, txSh_d;       // Outgoing bits
    logic pass_q, pass_d;             // Forwarding the chain input
    logic dout_q, dout_d;
    logic oe_q;

    // Falling edge: capture data and raise byte events
    always_comb begin
        bitCnt_d = bitCnt_q + 3'h1;
        rxSh_d = {rxSh_q[5:0], din};
        rxByte_d = rxByte_q;
        rxEarly_d = rxEarly_q;
        rxTog_d = rxTog_q;
        if (bitCnt_q == acs_pkg::EARLY_BIT_IDX) begin
            rxByte_d = {rxSh_q[5:0], din, 1'b0};
            rxEarly_d = 1'b1;
            rxTog_d = ~rxTog_q;
        end else if (bitCnt_q == acs_pkg::FULL_BIT_IDX) begin
            rxByte_d = {rxSh_q[6:0], din};
            rxEarly_d = 1'b0;
            rxTog_d = ~rxTog_q;
        end
    end

    // Bit position restarts whenever the frame closes
    always_ff @(negedge sclk or negedge reset_n or posedge csN) begin
        if (!reset_n) begin
            bitCnt_q <= 3'h0;
            rxSh_q <= 7'h00;
        end else if (csN) begin
            bitCnt_q <= 3'h0;
            rxSh_q <= 7'h00;
        end else begin
            bitCnt_q <= bitCnt_d;
            rxSh_q <= rxSh_d;
        end
    end

    // Event word survives chip-select changes so no event is lost
    always_ff @(negedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            rxByte_q <= 8'h00;
            rxEarly_q <= 1'b0;
            rxTog_q <= 1'b0;
        end else begin
            rxByte_q <= rxByte_d;
            rxEarly_q <= rxEarly_d;
            rxTog_q <= rxTog_d;
        end
    end

    // Rising edge: load at byte start, shift otherwise
    always_comb begin
        txSh_d = {txSh_q[6:0], 1'b0};
        pass_d = pass_q;
        if (bitCnt_q == 3'h0) begin
            txSh_d = {txByte[6:0], 1'b0};
            pass_d = txPass;
            dout_d = txPass ? chainIn : txByte[7];
        end else begin
            dout_d = pass_q ? chainIn : txSh_q[7];
        end
    end

    // Output driver; deselect releases the line at once
    always_ff @(posedge sclk or negedge reset_n or posedge csN) begin
        if (!reset_n) begin
            txSh_q <= 8'h00;
            pass_q <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (csN) begin
            txSh_q <= 8'h00;
            pass_q <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            txSh_q <= txSh_d;
            pass_q <= pass_d;
            dout_q <= dout_d;
            oe_q <= 1'b1;
        end
    end

    assign dout = dout_q;
    assign doutOe = oe_q;
    assign rxByte = rxByte_q;
    assign rxEarly = rxEarly_q;
    assign rxToggle = rxTog_q;

endmodule

// ==== rtl/acs_command_core.sv ====
// Command decoder and conversion sequencer for a multichannel converter.
// Assumes a host-driven four-wire serial port, a converter that presents
// its frame on frameData, and a register file reached over regAddr/regWr.
//
// How it works
// - single-shot: one conversion per start
// - single-shot end: done low, conversions halt
// - deselected device releases data output
// - chain: own data, then chain input
// - chain mode: no frame wraparound readback
// - output and chain input on rising edge
// - clock source and enable drive clock out
// - opcodes 02h wake, 04h standby, 06h reset
// - opcodes 08h start/resync, 0Ah stop
// - 10h, 11h, 12h read opcodes; power-up continuous
// - register opcodes: 2xh/4xh, count byte, data
// - decode system at 7th, register at 8th
// - register read ignored in continuous read
// - standby halts conversions and commands until wake
// - standby and wake accepted whenever no register command is open
// - start-to-done delay fixed per rate
// - count field is registers minus one
`timescale 1ns/100ps

module acs_command_core #(
    parameter int FRAME_BYTES = acs_pkg::FRAME_BYTES_DEF,
    parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES_DEF
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial port pins
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    input wire logic chainIn,
    output logic dout,
    output logic doutOe,
    // Conversion and clock pins
    input wire logic startPin,
    input wire logic clockSourceSelect,
    output logic conversionDoneN,
    output logic masterClkOut,
    // Setup bits
    input wire logic fourthSetupSingleShot,
    input wire logic firstSetupChainEn,
    input wire logic firstSetupClkOutEn,
    // Converter side
    input wire logic [FRAME_BYTES*8-1:0] frameData,
    output logic lowPower,
    output logic softResetPulse,
    // Register file side
    output logic [acs_pkg::FIELD_W-1:0] regAddr,
    output logic regWrStrobe,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);

    localparam int IDX_W = $clog2(FRAME_BYTES + 1);
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FRAME_BYTES - 1);
    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] RISE_CNT = CNT_W'(CONV_CYCLES - 2);

    // Link-side words
    logic [7:0] rxByte;
    logic rxEarly;
    logic rxToggle;
    logic [7:0] txByte_q, txByte_d;
    logic txPass_q, txPass_d;

    // Serial clock domain
    acs_serial_link u_link (
        .sclk(sclk),
        .csN(csN),
        .reset_n(reset_n),
        .din(din),
        .chainIn(chainIn),
        .dout(dout),
        .doutOe(doutOe),
        .txByte(txByte_q),
        .txPass(txPass_q),
        .rxByte(rxByte),
        .rxEarly(rxEarly),
        .rxToggle(rxToggle)
    );

    // Synchronisers: {clock source, start pin, select, event toggle}
    logic [3:0] sync1_q, sync2_q, prev_q;
    logic evt, earlyEvt, fullEvt, csRise, startRise, startFall, clkSrc;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 4'h2;
            sync2_q <= 4'h2;
            prev_q <= 4'h2;
        end else begin
            sync1_q <= {clockSourceSelect, startPin, csN, rxToggle};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Edge detection on the second stage only
    always_comb begin
        evt = sync2_q[0] ^ prev_q[0];
        earlyEvt = evt & rxEarly;
        fullEvt = evt & ~rxEarly;
        csRise = sync2_q[1] & ~prev_q[1];
        startRise = sync2_q[2] & ~prev_q[2];
        startFall = ~sync2_q[2] & prev_q[2];
        clkSrc = sync2_q[3];
    end

    // Command sequencer state
    acs_pkg::acs_cmd_t state_q, state_d;
    logic contRead_q, contRead_d;       // Continuous read active
    logic lowPower_q, lowPower_d;       // Standby
    logic rdArm_q, rdArm_d;             // Single read armed
    logic isWrite_q, isWrite_d;
    logic [acs_pkg::FIELD_W-1:0] addr_q, addr_d;
    logic [acs_pkg::FIELD_W-1:0] left_q, left_d;
    logic wrStb_q, wrStb_d;
    logic [7:0] wrData_q, wrData_d;
    logic softRst_q, softRst_d;
    logic startCmd, stopCmd;            // One-cycle decode strobes

    // Decode opcodes into next state
    always_comb begin
        state_d = state_q;
        contRead_d = contRead_q;
        lowPower_d = lowPower_q;
        rdArm_d = rdArm_q;
        isWrite_d = isWrite_q;
        addr_d = wrStb_q ? addr_q + 5'h01 : addr_q;
        left_d = left_q;
        wrStb_d = 1'b0;
        wrData_d = wrData_q;
        softRst_d = 1'b0;
        startCmd = 1'b0;
        stopCmd = 1'b0;
        if (csRise) begin
            // Frame closed: drop any partial command and the single read
            state_d = acs_pkg::CMD_IDLE;
            rdArm_d = 1'b0;
        end else begin
            case (state_q)
                acs_pkg::CMD_IDLE: begin
                    if (earlyEvt) begin
                        if (acs_pkg::acs_match7(rxByte, acs_pkg::WAKE_CMD)) begin
                            lowPower_d = 1'b0;
                        end else if (acs_pkg::acs_match7(rxByte, acs_pkg::STANDBY_CMD)) begin
                            lowPower_d = 1'b1;
                        end else if (lowPower_q) begin
                            // Standby: everything else is dropped
                            lowPower_d = 1'b1;
                        end else if (acs_pkg::acs_match7(rxByte, acs_pkg::RESET_CMD)) begin
                            softRst_d = 1'b1;
                            contRead_d = acs_pkg::CONT_READ_RST;
                            rdArm_d = 1'b0;
                        end else if (acs_pkg::acs_match7(rxByte, acs_pkg::START_CMD)) begin
                            startCmd = 1'b1;
                        end else if (acs_pkg::acs_match7(rxByte, acs_pkg::STOP_CMD)) begin
                            stopCmd = 1'b1;
                        end else if (acs_pkg::acs_match7(rxByte, acs_pkg::SINGLE_READ_CMD)) begin
                            rdArm_d = 1'b1;
                        end
                    end else if (fullEvt && !lowPower_q) begin
                        if (rxByte == acs_pkg::CONTINUOUS_READ_CMD) begin
                            contRead_d = 1'b1;
                        end else if (rxByte == acs_pkg::HALT_CONTINUOUS_READ_CMD) begin
                            contRead_d = 1'b0;
                        end else if (rxByte[7:acs_pkg::PREFIX_LSB] ==
                                     acs_pkg::REGISTER_READ_CMD && !contRead_q) begin
                            addr_d = rxByte[acs_pkg::FIELD_W-1:0];
                            isWrite_d = 1'b0;
                            state_d = acs_pkg::CMD_COUNT;
                        end else if (rxByte[7:acs_pkg::PREFIX_LSB] ==
                                     acs_pkg::REGISTER_WRITE_CMD) begin
                            addr_d = rxByte[acs_pkg::FIELD_W-1:0];
                            isWrite_d = 1'b1;
                            state_d = acs_pkg::CMD_COUNT;
                        end
                    end
                end
                acs_pkg::CMD_COUNT: begin
                    if (fullEvt) begin
                        left_d = rxByte[acs_pkg::FIELD_W-1:0];
                        state_d = isWrite_q ? acs_pkg::CMD_WRITE : acs_pkg::CMD_READ;
                    end
                end
                acs_pkg::CMD_WRITE: begin
                    if (fullEvt) begin
                        wrStb_d = 1'b1;
                        wrData_d = rxByte;
                        left_d = left_q - 5'h01;
                        if (left_q == 5'h00) begin
                            state_d = acs_pkg::CMD_IDLE;
                        end
                    end
                end
                acs_pkg::CMD_READ: begin
                    if (fullEvt) begin
                        addr_d = addr_q + 5'h01;
                        left_d = left_q - 5'h01;
                        if (left_q == 5'h00) begin
                            state_d = acs_pkg::CMD_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = acs_pkg::CMD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= acs_pkg::CMD_IDLE;
            contRead_q <= acs_pkg::CONT_READ_RST;
            lowPower_q <= 1'b0;
            rdArm_q <= 1'b0;
            isWrite_q <= 1'b0;
            addr_q <= 5'h00;
            left_q <= 5'h00;
            wrStb_q <= 1'b0;
            wrData_q <= 8'h00;
            softRst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            contRead_q <= contRead_d;
            lowPower_q <= lowPower_d;
            rdArm_q <= rdArm_d;
            isWrite_q <= isWrite_d;
            addr_q <= addr_d;
            left_q <= left_d;
            wrStb_q <= wrStb_d;
            wrData_q <= wrData_d;
            softRst_q <= softRst_d;
        end
    end

    // Conversion sequencer state
    logic running_q, running_d;
    logic stopPend_q, stopPend_d;       // Stop after the current conversion
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic doneN_q, doneN_d;
    logic latch;                        // Conversion completes this cycle

    // Start, stop and completion of conversions
    always_comb begin
        running_d = running_q;
        stopPend_d = stopPend_q;
        cnt_d = cnt_q;
        doneN_d = doneN_q;
        latch = 1'b0;
        if (softRst_q) begin
            running_d = 1'b0;
            stopPend_d = 1'b0;
            cnt_d = '0;
            doneN_d = acs_pkg::DONE_N_RST;
        end else if (startRise || startCmd) begin
            running_d = 1'b1;
            stopPend_d = 1'b0;
            cnt_d = '0;
            doneN_d = 1'b1;
        end else if (running_q && !lowPower_q) begin
            if (startFall || stopCmd) begin
                stopPend_d = 1'b1;
            end
            cnt_d = cnt_q + CNT_W'(1);
            if (cnt_q == LAST_CNT) begin
                latch = 1'b1;
                doneN_d = 1'b0;
                cnt_d = '0;
                if (fourthSetupSingleShot || stopPend_q || startFall || stopCmd) begin
                    running_d = 1'b0;
                    stopPend_d = 1'b0;
                end
            end else if (cnt_q == RISE_CNT && !fourthSetupSingleShot) begin
                // Continuous: brief high before the next result
                doneN_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            running_q <= 1'b0;
            stopPend_q <= 1'b0;
            cnt_q <= '0;
            doneN_q <= acs_pkg::DONE_N_RST;
        end else begin
            running_q <= running_d;
            stopPend_q <= stopPend_d;
            cnt_q <= cnt_d;
            doneN_q <= doneN_d;
        end
    end

    // Result frame memory, byte 0 is the first out
    logic [7:0] frameMem_q [FRAME_BYTES];
    logic [7:0] frameMem_d [FRAME_BYTES];

    always_comb begin
        for (int i = 0; i < FRAME_BYTES; i++) begin
            frameMem_d[i] = latch ? frameData[(FRAME_BYTES-1-i)*8 +: 8] : frameMem_q[i];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < FRAME_BYTES; i++) begin
                frameMem_q[i] <= 8'h00;
            end
        end else begin
            frameMem_q <= frameMem_d;
        end
    end

    // Output byte selection and frame position
    logic [IDX_W-1:0] idx_q, idx_d;
    logic passing_q, passing_d;         // Own frame done, forwarding chain
    logic srcFrame_q, srcFrame_d;       // Byte now shifting comes from the frame
    logic streaming;

    always_comb begin
        streaming = contRead_q | rdArm_q;
        idx_d = idx_q;
        passing_d = passing_q;
        // Single read opcode byte holds no frame data
        srcFrame_d = (csRise || fullEvt) ? (contRead_d | rdArm_d) : srcFrame_q;
        if (csRise || latch) begin
            idx_d = '0;
            passing_d = 1'b0;
        end else if (fullEvt && srcFrame_q && state_q == acs_pkg::CMD_IDLE && !passing_q) begin
            if (idx_q == LAST_IDX) begin
                idx_d = '0;
                passing_d = firstSetupChainEn;
            end else begin
                idx_d = idx_q + IDX_W'(1);
            end
        end
        txPass_d = 1'b0;
        if (state_q == acs_pkg::CMD_READ) begin
            txByte_d = regRdData;
        end else if (passing_q) begin
            txByte_d = acs_pkg::TX_IDLE_BYTE;
            txPass_d = 1'b1;
        end else if (streaming) begin
            txByte_d = frameMem_q[idx_q];
        end else begin
            txByte_d = acs_pkg::TX_IDLE_BYTE;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idx_q <= '0;
            passing_q <= 1'b0;
            srcFrame_q <= acs_pkg::CONT_READ_RST;
            txByte_q <= acs_pkg::TX_IDLE_BYTE;
            txPass_q <= 1'b0;
        end else begin
            idx_q <= idx_d;
            passing_q <= passing_d;
            srcFrame_q <= srcFrame_d;
            txByte_q <= txByte_d;
            txPass_q <= txPass_d;
        end
    end

    // Master clock output, half the system clock
    logic mclk_q, mclk_d;

    always_comb begin
        mclk_d = (clkSrc && firstSetupClkOutEn) ? ~mclk_q : 1'b0;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mclk_q <= 1'b0;
        end else begin
            mclk_q <= mclk_d;
        end
    end

    // Registered outputs
    assign conversionDoneN = doneN_q;
    assign masterClkOut = mclk_q;
    assign lowPower = lowPower_q;
    assign softResetPulse = softRst_q;
    assign regAddr = addr_q;
    assign regWrStrobe = wrStb_q;
    assign regWrData = wrData_q;

endmodule

// ==== sim/acs_command_core_chk.sv ====
// Checker for the command core, bound to its top-level ports.
// Assumes the bench shrinks the conversion count to 16 or more.
`timescale 1ns/100ps
module acs_command_core_chk #(
    parameter int CONV_CYCLES = 1024
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Watched ports
    input wire logic csN,
    input wire logic doutOe,
    input wire logic startPin,
    input wire logic clockSourceSelect,
    input wire logic firstSetupClkOutEn,
    input wire logic fourthSetupSingleShot,
    input wire logic conversionDoneN,
    input wire logic masterClkOut,
    input wire logic lowPower,
    input wire logic softResetPulse,
    input wire logic regWrStrobe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Cycles the done flag has stayed high
    logic [15:0] hiCnt_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) hiCnt_q <= 16'h0;
        else hiCnt_q <= conversionDoneN ? hiCnt_q + 16'h1 : 16'h0;
    end
    // Deselected, single-shot, start pin steady
    sequence s_quiet;
        (csN && fourthSetupSingleShot && $stable(startPin))[*8];
    endsequence
    chk_oe_off: assert property (csN |-> !doutOe) else $error("dout on while idle");
    chk_done_holds: assert property (s_quiet ##0 !conversionDoneN |=> !conversionDoneN)
        else $error("done flag rose by itself");
    chk_conv_width: assert property ($fell(conversionDoneN) && fourthSetupSingleShot
        |-> hiCnt_q >= CONV_CYCLES - 3) else $error("conversion too short");
    chk_clk_off: assert property ((!(clockSourceSelect && firstSetupClkOutEn))[*6]
        |-> !masterClkOut) else $error("clock out while disabled");
    chk_clk_runs: assert property ((clockSourceSelect && firstSetupClkOutEn)[*6]
        |-> masterClkOut != $past(masterClkOut)) else $error("clock out stuck");
    chk_wr_pulse: assert property (regWrStrobe |=> !regWrStrobe) else $error("long strobe");
    chk_rst_pulse: assert property (softResetPulse |=> !softResetPulse) else $error("long reset");
    chk_standby_calm: assert property (lowPower && $past(lowPower, 2)
        |-> !regWrStrobe && !softResetPulse && $stable(conversionDoneN)) else $error("standby busy");
endmodule
bind acs_command_core acs_command_core_chk #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.clk_sys, .reset_n,
    .csN, .doutOe, .startPin, .clockSourceSelect, .firstSetupClkOutEn, .fourthSetupSingleShot,
    .conversionDoneN, .masterClkOut, .lowPower, .softResetPulse, .regWrStrobe);

// ==== sim/acs_host_model.sv ====
// Host serial master for the command core's four-wire port.
// Assumes one caller at a time; the link clock idles low.
`timescale 1ns/100ps
module acs_host_model (
    // Pins driven by the host
    output logic sclk,
    output logic csN,
    output logic din,
    // Pin read back
    input wire logic dout
);
    // Idle: clock low, device deselected
    initial begin
        sclk = 1'h0;
        csN = 1'h1;
        din = 1'h0;
    end
    task automatic sel(input logic on);
        #43 csN = !on;
        #40;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            #1 din = tx[i];
            #39 sclk = 1'h1;
            #40 rx[i] = dout;
            sclk = 1'h0;
        end
        // Released data line keeps moving
        #1 din = ~din;
    endtask
    task automatic tick();
        #40 sclk = 1'h1;
        #40 sclk = 1'h0;
    endtask
endmodule

// ==== sim/acs_command_core_test.sv ====
// Self-checking bench for the command core with a host serial model.
// Assumes a 16-cycle conversion and a three-byte frame.
`timescale 1ns/100ps
module acs_command_core_test;
    localparam int CONV = 16;
    // Inputs, all given values at time zero
    logic clk_sys = 1'h0, reset_n = 1'h0, startPin = 1'h0, chainIn = 1'h1;
    logic clockSourceSelect = 1'h0, firstSetupClkOutEn = 1'h0, firstSetupChainEn = 1'h0;
    logic fourthSetupSingleShot = 1'h1;
    logic [23:0] frameData = 24'hC38196;
    // Outputs and bench state
    logic sclk, csN, din, dout, doutOe, doutBus, conversionDoneN, masterClkOut;
    logic lowPower, softResetPulse, regWrStrobe, doneQ;
    logic [acs_pkg::FIELD_W-1:0] regAddr;
    logic [7:0] regWrData, regRdData, rx;
    logic [31:0] rxw, d1, d2, n, ups = 32'h0, rstSeen = 32'h0;
    logic [31:0] wrLog [$];
    int bad_count = 0, check_count = 0, cycles = 0;
    // Register file stand-in; released output shows the inverse level
    assign regRdData = {3'h3, regAddr};
    assign doutBus = doutOe ? dout : !dout;
    acs_command_core #(.FRAME_BYTES(3), .CONV_CYCLES(CONV)) dut_u (.clk_sys, .reset_n, .sclk,
        .csN, .din, .chainIn, .dout, .doutOe, .startPin, .clockSourceSelect, .conversionDoneN,
        .masterClkOut, .fourthSetupSingleShot, .firstSetupChainEn, .firstSetupClkOutEn,
        .frameData, .lowPower, .softResetPulse, .regAddr, .regWrStrobe, .regWrData, .regRdData);
    acs_host_model host_u (.sclk, .csN, .din, .dout(doutBus));
    always #2.5 clk_sys = ~clk_sys;
    // Pulse counters, write capture and run limit
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        doneQ <= conversionDoneN;
        if (conversionDoneN === 1'h1 && doneQ === 1'h0) ups <= ups + 32'h1;
        if (softResetPulse === 1'h1) rstSeen <= rstSeen + 32'h1;
        if (regWrStrobe === 1'h1) wrLog.push_back({19'h0, regAddr, regWrData});
        if (cycles == 30000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One framed command of n bytes; rxw keeps the last four bytes read
    task automatic cmd(input logic [31:0] w, input int n, input int t = 9);
        host_u.sel(1'h1);
        for (int i = 0; i < n; i++) begin
            if (i == t) host_u.tick();
            host_u.xfer(w[31-8*i -: 8], rx);
            rxw = {rxw[23:0], rx};
        end
        host_u.sel(1'h0);
    endtask
    // Cycles from now until done falls, after it first stands high
    task automatic waitDone(output logic [31:0] d);
        d = 0;
        while (conversionDoneN !== 1'h1 && d < 9) begin
            @(negedge clk_sys) d++;
        end
        while (conversionDoneN !== 1'h0 && d < 300) begin
            @(negedge clk_sys) d++;
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'h1;
        repeat (6) @(posedge clk_sys);
        startPin <= 1'h1;
        waitDone(d1);
        chk(d1 >= CONV && d1 <= CONV + 8, 1);
        repeat (60) @(negedge clk_sys);
        chk(conversionDoneN, 0);
        @(posedge clk_sys) startPin <= 1'h0;
        repeat (8) @(posedge clk_sys);
        startPin <= 1'h1;
        waitDone(d2);
        chk(d2, d1);
        @(posedge clk_sys) startPin <= 1'h0;
        cmd(32'h11000000, 1);
        n = ups;
        cmd(32'h08000000, 1);
        repeat (60) @(negedge clk_sys);
        chk(ups, n + 1);
        @(posedge clk_sys) fourthSetupSingleShot <= 1'h0;
        n = ups;
        cmd(32'h08000000, 1);
        cmd(32'h0A000000, 1);
        repeat (40) @(negedge clk_sys);
        chk(ups > n + 2, 1);
        n = ups;
        repeat (100) @(negedge clk_sys);
        chk(ups, n);
        @(posedge clk_sys) fourthSetupSingleShot <= 1'h1;
        cmd(32'h04000000, 1);
        chk(lowPower, 1);
        cmd(32'h02000000, 1);
        chk(lowPower, 0);
        repeat (8) @(posedge clk_sys);
        cmd(32'h06000000, 1);
        cmd(32'hF0000000, 1);
        chk({lowPower, rstSeen[30:0]}, 1);
        cmd(32'h22000000, 3);
        chk(rxw & 32'hFF, 32'h96);
        cmd(32'h0, 4);
        chk(rxw, 32'hC38196C3);
        chk(doutOe, 0);
        @(posedge clk_sys) firstSetupChainEn <= 1'h1;
        cmd(32'h0, 4, 3);
        chk(rxw, 32'hC38196FF);
        cmd(32'h11000000, 1);
        cmd(32'h12000000, 4);
        chk(rxw, 32'h00C38196);
        cmd(32'h4101A53C, 4);
        chk(wrLog[0], 32'h1A5);
        chk(wrLog[1], 32'h23C);
        cmd(32'h22010000, 4);
        chk(rxw & 32'hFFFF, 32'h6263);
        @(posedge clk_sys) {clockSourceSelect, firstSetupClkOutEn} <= 2'h3;
        repeat (10) @(negedge clk_sys);
        n = 0;
        repeat (20) @(negedge clk_sys) n += masterClkOut;
        chk(n, 32'hA);
        stop_test();
    end
endmodule
